// ### hdl/dtmr_burst_if.sv
// launch and data signals between the command logic and the pattern reader
// assumes both ends run on the link clock
`default_nettype none

interface dtmr_burst_if;
  logic start;
  logic chop;
  logic upper;
  logic [1:0] loc;
  logic [7:0] dq_rise;
  logic [7:0] dq_fall;
  logic dq_oe;
  logic busy;

  modport ctrl (
    output start, chop, upper, loc,
    input dq_rise, dq_fall, dq_oe, busy
  );

  modport reader (
    input start, chop, upper, loc,
    output dq_rise, dq_fall, dq_oe, busy
  );
endinterface

`default_nettype wire

// ### hdl/dtmr_pattern_reader.sv
// serialiser that bursts the calibration pattern out, two beats per clock
// assumes start is raised in the cycle before the first data pair is due
`default_nettype none

module dtmr_pattern_reader (
  // link clock, reset and enable
  input wire logic ck,
  input wire logic lrst_n,
  input wire logic len,
  // launch and data
  dtmr_burst_if.reader bus
);
  import dtmr_pkg::*;

  dtmr_rd_state_t state_q;
  logic [1:0] idx_q;
  logic [1:0] last_q;
  logic [7:0] word_q;
  logic [1:0] first;
  logic [7:0] pat;

  function automatic logic [7:0] expand(input logic b);
    expand = {{7{b & CAL_MIRROR_DQ}}, b};
  endfunction

  assign first = bus.upper ? 2'h2 : 2'h0;
  assign pat = (bus.loc == LOC_PATTERN) ? CAL_PATTERN_LOC0
                                        : CAL_PATTERN_RSVD;
  assign bus.busy = (state_q == RD_BURST);

  ////////////////////////////////////////////////////////////////////////////
  // burst position
  always_ff @(posedge ck) begin
    if (!lrst_n) begin
      state_q <= RD_IDLE;
      idx_q <= 2'h0;
      last_q <= 2'h0;
      word_q <= 8'h00;
    end else if (len) begin
      if (bus.start) begin
        word_q <= pat;
        idx_q <= first + 2'h1;
        last_q <= bus.chop ? first + 2'h1 : 2'h3;
        state_q <= RD_BURST;
      end else begin
        case (state_q)
          RD_BURST: begin
            idx_q <= idx_q + 2'h1;
            if (idx_q == last_q) begin
              state_q <= RD_IDLE;
            end
          end
          RD_IDLE: begin
            state_q <= RD_IDLE;
          end
          default: begin
            state_q <= RD_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output pair, low burst position on the rising half
  always_ff @(posedge ck) begin
    if (!lrst_n) begin
      bus.dq_rise <= 8'h00;
      bus.dq_fall <= 8'h00;
      bus.dq_oe <= 1'b0;
    end else if (len) begin
      if (bus.start) begin
        bus.dq_rise <= expand(pat[{first, 1'b0}]);
        bus.dq_fall <= expand(pat[{first, 1'b1}]);
        bus.dq_oe <= 1'b1;
      end else if (state_q == RD_BURST) begin
        bus.dq_rise <= expand(word_q[{idx_q, 1'b0}]);
        bus.dq_fall <= expand(word_q[{idx_q, 1'b1}]);
        bus.dq_oe <= 1'b1;
      end else begin
        bus.dq_rise <= 8'h00;
        bus.dq_fall <= 8'h00;
        bus.dq_oe <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// ### hdl/dtmr_pkg.sv
// constants for the calibration readout and write-leveling exit block
// assumes a link clock of 160 ns and mode register writes on the link pins
`default_nettype none

package dtmr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int LINK_PERIOD_NS = 160;
  localparam int T_MOD_NCK = 12;
  localparam int T_MOD_NS = 15;
  localparam int T_MRD_NCK = 4;
  localparam int T_MOD_NS_CYC =
    (T_MOD_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int T_MOD_CYC =
    (T_MOD_NCK > T_MOD_NS_CYC) ? T_MOD_NCK : T_MOD_NS_CYC;
  localparam logic [4:0] MOD_LOAD = 5'(T_MOD_CYC - 1);
  localparam logic [4:0] MRD_LOAD = 5'(T_MRD_NCK - 1);
  localparam logic [4:0] TIMER_ZERO = 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // mode register select and field positions
  localparam logic [2:0] MR_SEL_0 = 3'h0;
  localparam logic [2:0] MR_SEL_1 = 3'h1;
  localparam logic [2:0] MR_SEL_3 = 3'h3;
  localparam int MR0_BL_LSB = 0;
  localparam int MR0_CL_HI_BIT = 2;
  localparam int MR0_CL_LSB = 4;
  localparam int MR1_AL_LSB = 3;
  localparam int MR1_WL_BIT = 7;
  localparam int MR3_LOC_LSB = 0;
  localparam int MR3_CAL_BIT = 2;
  localparam int ADDR_NIBBLE_BIT = 2;
  localparam int ADDR_CHOP_BIT = 12;
  localparam int ADDR_ALL_BANKS_BIT = 10;

  ////////////////////////////////////////////////////////////////////////////
  // field codes and reset values
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [1:0] AL_ZERO = 2'h0;
  localparam logic [1:0] AL_CL1 = 2'h1;
  localparam logic [1:0] AL_CL2 = 2'h2;
  localparam logic [4:0] CL_OFFSET = 5'h04;
  localparam logic [4:0] LAT_TAP_OFFSET = 5'h01;
  localparam logic [1:0] LOC_PATTERN = 2'h0;
  localparam logic [13:0] MR_RESET = 14'h0000;
  localparam int LAT_DEPTH = 32;

  ////////////////////////////////////////////////////////////////////////////
  // calibration pattern, burst position 0 in the lsb
  localparam logic [7:0] CAL_PATTERN_LOC0 = 8'hAA;
  localparam logic [7:0] CAL_PATTERN_RSVD = 8'h00;
  localparam logic CAL_MIRROR_DQ = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // command kinds and reader states
  typedef enum logic [6:0] {
    CMD_NOP = 7'b000_0001,
    CMD_MRS = 7'b000_0010,
    CMD_READ = 7'b000_0100,
    CMD_WRITE = 7'b000_1000,
    CMD_ACT = 7'b001_0000,
    CMD_PRE = 7'b010_0000,
    CMD_OTHER = 7'b100_0000
  } dtmr_cmd_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_BURST = 2'b10
  } dtmr_rd_state_t;

endpackage

`default_nettype wire

// ### hdl/dtmr_top.sv
// command decode, write-leveling exit and calibration readout of the device
// assumes command pins are launched on the link clock; status leaves on mclk
`default_nettype none

// What this block does
// - MR1 bit seven enters, leaves write leveling
// - data undefined until tMOD after exit
// - commands after tMOD, mode writes after tMRD
// - MR3 bit two enables calibration mode
// - reads come from calibration register
// - auto precharge read acts as plain read
// - reset still works in calibration mode
// - mode off ignores location, reads drive no data
// - bit on line zero, others mirror
// - low column bits zero, rest ignored
// - full burst returns order zero to seven
// - chopped nibble chosen by column bit two
// - chop on the fly or fixed
// - ordinary read latency AL plus CL
// - location zero gives alternating pattern
// - burst position zero is the lsb
module dtmr_top (
  // core clock, reset and enable
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  // link clock and command pins
  input wire logic ck,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [13:0] addr,
  input wire logic odt,
  // data and strobe drive
  output logic [7:0] dq_rise,
  output logic [7:0] dq_fall,
  output logic dq_oe,
  output logic dqs_oe,
  // status on mclk
  output logic wl_mode,
  output logic calib_mode,
  output logic dq_undefined,
  output logic cmd_ready,
  output logic mrs_ready,
  output logic cmd_violation
);
  import dtmr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // link side reset and enable
  logic lrst_s1_q;
  logic lrst_s2_q;
  logic len_s1_q;
  logic len_s2_q;
  logic lrst_n;
  logic len;

  always_ff @(posedge ck) begin
    lrst_s1_q <= rstn;
    lrst_s2_q <= lrst_s1_q;
    len_s1_q <= clk_en;
    len_s2_q <= len_s1_q;
  end

  assign lrst_n = lrst_s2_q;
  assign len = len_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  function automatic dtmr_cmd_t decode(input logic c, input logic r,
                                       input logic a, input logic w);
    dtmr_cmd_t k;
    k = CMD_OTHER;
    if (c) begin
      k = CMD_NOP;
    end else begin
      case ({r, a, w})
        3'h0: k = CMD_MRS;
        3'h5: k = CMD_READ;
        3'h4: k = CMD_WRITE;
        3'h3: k = CMD_ACT;
        3'h2: k = CMD_PRE;
        3'h7: k = CMD_NOP;
        default: k = CMD_OTHER;
      endcase
    end
    decode = k;
  endfunction

  function automatic logic [4:0] read_latency(input logic [13:0] mr0,
                                              input logic [13:0] mr1);
    logic [4:0] cl;
    logic [1:0] al;
    cl = {1'b0, mr0[MR0_CL_LSB +: 3], mr0[MR0_CL_HI_BIT]} >> 1;
    cl = cl + CL_OFFSET;
    al = mr1[MR1_AL_LSB +: 2];
    case (al)
      AL_CL1: read_latency = cl + cl - 5'h01;
      AL_CL2: read_latency = cl + cl - 5'h02;
      default: read_latency = cl;
    endcase
  endfunction

  dtmr_cmd_t cmd;
  logic is_mrs;
  logic is_read;
  logic [13:0] mr0_q;
  logic [13:0] mr1_q;
  logic [1:0] loc_q;
  logic wl_q;
  logic cal_q;

  assign cmd = decode(cs_n, ras_n, cas_n, we_n);
  assign is_mrs = (cmd == CMD_MRS);
  assign is_read = (cmd == CMD_READ);

  ////////////////////////////////////////////////////////////////////////////
  // mode registers
  always_ff @(posedge ck) begin
    if (!lrst_n) begin
      mr0_q <= MR_RESET;
      mr1_q <= MR_RESET;
      loc_q <= LOC_PATTERN;
      wl_q <= 1'b0;
      cal_q <= 1'b0;
    end else if (len && is_mrs) begin
      case (ba)
        MR_SEL_0: begin
          mr0_q <= addr;
        end
        MR_SEL_1: begin
          mr1_q <= addr;
          wl_q <= addr[MR1_WL_BIT];
        end
        MR_SEL_3: begin
          cal_q <= addr[MR3_CAL_BIT];
          loc_q <= addr[MR3_LOC_LSB +: 2];
        end
        default: begin
          wl_q <= wl_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode write recovery timers
  logic [4:0] mod_cnt_q;
  logic [4:0] mrd_cnt_q;

  always_ff @(posedge ck) begin
    if (!lrst_n) begin
      mod_cnt_q <= TIMER_ZERO;
      mrd_cnt_q <= TIMER_ZERO;
    end else if (len) begin
      if (is_mrs) begin
        mod_cnt_q <= MOD_LOAD;
        mrd_cnt_q <= MRD_LOAD;
      end else begin
        if (mod_cnt_q != TIMER_ZERO) begin
          mod_cnt_q <= mod_cnt_q - 5'h01;
        end
        if (mrd_cnt_q != TIMER_ZERO) begin
          mrd_cnt_q <= mrd_cnt_q - 5'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data pins undefined from leveling entry until tMOD after exit
  logic undef_q;
  logic wl_exit;

  assign wl_exit = is_mrs && (ba == MR_SEL_1) && !addr[MR1_WL_BIT] && wl_q;

  always_ff @(posedge ck) begin
    if (!lrst_n) begin
      undef_q <= 1'b0;
    end else if (len) begin
      if (is_mrs && (ba == MR_SEL_1) && addr[MR1_WL_BIT]) begin
        undef_q <= 1'b1;
      end else if (!wl_q && (mod_cnt_q == 5'h01) && !is_mrs) begin
        undef_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open rows; calibration entry with any row still open is flagged as a violation but still taken
  logic [7:0] open_q;
  logic cal_entry;

  assign cal_entry = is_mrs && (ba == MR_SEL_3) && addr[MR3_CAL_BIT];

  always_ff @(posedge ck) begin
    if (!lrst_n) begin
      open_q <= 8'h00;
    end else if (len) begin
      case (cmd)
        CMD_ACT: begin
          open_q[ba] <= 1'b1;
        end
        CMD_PRE: begin
          if (addr[ADDR_ALL_BANKS_BIT]) begin
            open_q <= 8'h00;
          end else begin
            open_q[ba] <= 1'b0;
          end
        end
        default: begin
          open_q <= open_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flag for commands the device cannot honour
  logic viol_q;
  logic viol_now;

  always_comb begin
    viol_now = 1'b0;
    if (is_mrs && (mrd_cnt_q != TIMER_ZERO)) begin
      viol_now = 1'b1;
    end
    if (!is_mrs && (cmd != CMD_NOP) && (mod_cnt_q != TIMER_ZERO)) begin
      viol_now = 1'b1;
    end
    if (cal_q && !is_mrs && (cmd != CMD_NOP) && !is_read) begin
      viol_now = 1'b1;
    end
    if (wl_q && !is_mrs && (cmd != CMD_NOP)) begin
      viol_now = 1'b1;
    end
    if (wl_exit && odt) begin
      viol_now = 1'b1;
    end
    if (cal_entry && (open_q != 8'h00)) begin
      viol_now = 1'b1;
    end
  end

  always_ff @(posedge ck) begin
    if (!lrst_n) begin
      viol_q <= 1'b0;
    end else if (len && viol_now) begin
      viol_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read latency line; bank, auto precharge select and other column bits
  // are not looked at
  logic [2:0] lat_line_q [0:LAT_DEPTH-1];
  logic [4:0] rl;
  logic [4:0] tap;
  logic chop_now;
  logic [2:0] lat_out;

  assign rl = read_latency(mr0_q, mr1_q);

  always_comb begin
    case (mr0_q[MR0_BL_LSB +: 2])
      BL_OTF: chop_now = !addr[ADDR_CHOP_BIT];
      BL_FIXED4: chop_now = 1'b1;
      default: chop_now = 1'b0;
    endcase
  end

  assign tap = rl - LAT_TAP_OFFSET;
  assign lat_out = lat_line_q[tap];

  always_ff @(posedge ck) begin
    if (!lrst_n) begin
      for (int i = 0; i < LAT_DEPTH; i++) begin
        lat_line_q[i] <= 3'h0;
      end
    end else if (len) begin
      // read with auto precharge lands here too, nothing is closed
      lat_line_q[0] <= {is_read && cal_q, chop_now,
                        chop_now && addr[ADDR_NIBBLE_BIT]};
      for (int i = 1; i < LAT_DEPTH; i++) begin
        lat_line_q[i] <= lat_line_q[i-1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pattern reader
  dtmr_burst_if burst ();

  assign burst.start = lat_out[2];
  assign burst.chop = lat_out[1];
  assign burst.upper = lat_out[0];
  assign burst.loc = loc_q;

  dtmr_pattern_reader u_reader (
    .ck(ck),
    .lrst_n(lrst_n),
    .len(len),
    .bus(burst.reader)
  );

  assign dq_rise = burst.dq_rise;
  assign dq_fall = burst.dq_fall;
  assign dq_oe = burst.dq_oe;
  assign dqs_oe = burst.dq_oe;

  ////////////////////////////////////////////////////////////////////////////
  // status levels into the core domain
  logic [5:0] lvl_link;
  logic [5:0] lvl_s1_q;
  logic [5:0] lvl_s2_q;

  assign lvl_link = {viol_q, (mrd_cnt_q == TIMER_ZERO),
                     (mod_cnt_q == TIMER_ZERO), undef_q, cal_q, wl_q};

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      lvl_s1_q <= 6'h00;
      lvl_s2_q <= 6'h00;
    end else if (clk_en) begin
      lvl_s1_q <= lvl_link;
      lvl_s2_q <= lvl_s1_q;
    end
  end

  assign wl_mode = lvl_s2_q[0];
  assign calib_mode = lvl_s2_q[1];
  assign dq_undefined = lvl_s2_q[2];
  assign cmd_ready = lvl_s2_q[3];
  assign mrs_ready = lvl_s2_q[4];
  assign cmd_violation = lvl_s2_q[5];
endmodule

`default_nettype wire

// ### test/dtmr_ctrl_model.sv
// controller model for the command, address and termination pins
// assumes the device samples these pins on the rising link clock edge
`default_nettype none

module dtmr_ctrl_model (
  // link clock
  input wire logic ck,
  // command and termination pins
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] ba,
  output logic [13:0] addr,
  output logic odt
);
  timeunit 1ns;
  timeprecision 1ns;
  import dtmr_pkg::*;

  initial begin
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    ba = 3'h0;
    addr = 14'h0000;
    odt = 1'b0;
  end
  // one link cycle of command, then deselect with lines inverted
  task automatic send(logic [3:0] pins, logic [2:0] b, logic [13:0] a);
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} = pins;
    ba = b;
    addr = a;
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    ba = ~b;
    addr = ~a;
  endtask
  task automatic mode_set(logic [2:0] b, logic [13:0] a);
    send(4'h0, b, a);
    repeat (T_MOD_CYC) @(negedge ck);
  endtask
  task automatic read_cal(logic [2:0] b, logic [13:0] a);
    send(4'h5, b, a & 14'h3FFC);
  endtask
  // termination pin level from the next falling link edge on
  task automatic drive_odt(logic v);
    @(negedge ck);
    odt = v;
  endtask
endmodule

`default_nettype wire

// ### test/dtmr_top_properties.sv
// checker for the calibration readout top, watching its ports only
// assumes location zero is the only calibration location read
`default_nettype none

module dtmr_top_properties (
  // clocks and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ck,
  // command pins
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [13:0] addr,
  // outputs
  input wire logic [7:0] dq_rise,
  input wire logic [7:0] dq_fall,
  input wire logic dq_oe,
  input wire logic dqs_oe,
  input wire logic cmd_ready,
  input wire logic mrs_ready,
  input wire logic cmd_violation
);
  logic [13:0] mr0_q, mr1_q;
  logic cal_q, chop_q;
  logic [4:0] cnt_q, rl;
  wire logic mrs = !cs_n && !ras_n && !cas_n && !we_n;
  wire logic rd = !cs_n && ras_n && !cas_n && we_n;
  // read latency from the tracked mode registers
  always_comb begin
    rl = 5'(mr0_q[6:4]) + 5'h04;
    if (mr1_q[4:3] == 2'h1) rl = rl + rl - 5'h01;
    else if (mr1_q[4:3] == 2'h2) rl = rl + rl - 5'h02;
  end
  always_ff @(posedge ck) begin
    if (!rstn) begin
      mr0_q <= 14'h0000;
      mr1_q <= 14'h0000;
      cal_q <= 1'b0;
    end else if (mrs) begin
      if (ba == 3'h0) mr0_q <= addr;
      if (ba == 3'h1) mr1_q <= addr;
      if (ba == 3'h3) cal_q <= addr[2];
    end
  end
  // counts down to the edge that must launch the burst
  always_ff @(posedge ck) begin
    if (!rstn) begin
      cnt_q <= 5'h00;
      chop_q <= 1'b0;
    end else if (rd && cal_q) begin
      cnt_q <= rl;
      chop_q <= mr0_q[1:0] == 2'h2 || (mr0_q[1:0] == 2'h1 && !addr[12]);
    end else if (cnt_q != 5'h00) begin
      cnt_q <= cnt_q - 5'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_read_latency: assert property (@(posedge ck) disable iff (!rstn)
    cnt_q == 5'h01 |=> dq_oe) else $error("burst start wrong");
  a_full_burst: assert property (@(posedge ck) disable iff (!rstn)
    cnt_q == 5'h01 && !chop_q |=> dq_oe [*4] ##1 !dq_oe)
    else $error("full burst length wrong");
  a_chop_burst: assert property (@(posedge ck) disable iff (!rstn)
    cnt_q == 5'h01 && chop_q |=> dq_oe [*2] ##1 !dq_oe)
    else $error("chopped burst length wrong");
  a_oe_cause: assert property (@(posedge ck) disable iff (!rstn)
    $rose(dq_oe) |-> $past(cnt_q) == 5'h01) else $error("data without read");
  a_pattern_beats: assert property (@(posedge ck) disable iff (!rstn)
    dq_oe |-> dq_rise == 8'h00 && dq_fall == 8'hFF)
    else $error("pattern beats wrong");
  a_strobe_pair: assert property (@(posedge ck) disable iff (!rstn)
    dqs_oe == dq_oe) else $error("strobe drive differs");
  a_flag_sticky: assert property (@(posedge mclk) disable iff (!rstn)
    cmd_violation |=> cmd_violation) else $error("violation flag lost");
  a_mrd_first: assert property (@(posedge mclk) disable iff (!rstn)
    cmd_ready |-> mrs_ready) else $error("ready order wrong");
  c_full: cover property (@(posedge ck) cnt_q == 5'h01 && !chop_q);
  c_chop: cover property (@(posedge ck) cnt_q == 5'h01 && chop_q);
  c_flag: cover property (@(posedge mclk) $rose(cmd_violation));
endmodule

bind dtmr_top dtmr_top_properties i_dtmr_top_properties (
  .mclk, .rstn, .ck, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dq_rise,
  .dq_fall, .dq_oe, .dqs_oe, .cmd_ready, .mrs_ready, .cmd_violation
);

`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the calibration readout and leveling exit
// assumes the controller model drives all command pins of the top
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dtmr_pkg::*;
  logic mclk = 1'b0;
  logic ck = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic cs_n, ras_n, cas_n, we_n, odt, dq_oe, dqs_oe;
  logic wl_mode, calib_mode, dq_undefined;
  logic cmd_ready, mrs_ready, cmd_violation;
  logic [2:0] ba;
  logic [13:0] addr;
  logic [7:0] dq_rise, dq_fall;
  int fail_count = 0;
  int checks_done = 0;

  always #50 mclk = ~mclk;
  always #80 ck = ~ck;

  dtmr_top i_dtmr_top (
    .mclk, .rstn, .clk_en, .ck, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr,
    .odt, .dq_rise, .dq_fall, .dq_oe, .dqs_oe, .wl_mode, .calib_mode,
    .dq_undefined, .cmd_ready, .mrs_ready, .cmd_violation
  );
  dtmr_ctrl_model i_dtmr_ctrl_model (
    .ck, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .odt
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic do_reset();
    rstn = 1'b0;
    repeat (12) @(negedge mclk);
    rstn = 1'b1;
    repeat (6) @(negedge ck);
  endtask
  task automatic mode(logic [2:0] b, logic [13:0] a);
    i_dtmr_ctrl_model.mode_set(b, a);
  endtask
  // one read, then measure latency, length and beats of the burst
  task automatic burst(logic [2:0] b, logic [13:0] a, logic [15:0] rl,
                       logic [15:0] len);
    logic [15:0] first;
    logic [15:0] n;
    first = 16'h0000;
    n = 16'h0000;
    i_dtmr_ctrl_model.read_cal(b, a);
    for (int k = 1; k < 24; k++) begin
      @(negedge ck);
      if (dq_oe === 1'b1) begin
        if (first == 16'h0000) first = 16'(k);
        n++;
        check({dq_fall, dq_rise}, 16'hFF00);
        check(dqs_oe, 1'b1);
      end
    end
    check(first, rl);
    check(n, len);
  endtask
  task automatic t_leveling();
    i_dtmr_ctrl_model.send(4'h0, 3'h1, 14'h0080);
    repeat (5) @(negedge mclk);
    check({wl_mode, dq_undefined}, 2'h3);
    repeat (T_MOD_CYC) @(negedge ck);
    i_dtmr_ctrl_model.send(4'h0, 3'h1, 14'h0000);
    repeat (7) @(negedge ck);
    check({wl_mode, dq_undefined, mrs_ready, cmd_ready}, 4'h6);
    repeat (T_MOD_CYC) @(negedge ck);
    check({wl_mode, dq_undefined, cmd_ready}, 3'h1);
  endtask
  task automatic t_calib();
    mode(3'h0, 14'h0011);
    mode(3'h1, 14'h0000);
    mode(3'h3, 14'h0004);
    check(calib_mode, 1'b1);
    burst(3'h0, 14'h1000, 16'h0005, 16'h0004);
    burst(3'h0, 14'h0000, 16'h0005, 16'h0002);
    burst(3'h0, 14'h0004, 16'h0005, 16'h0002);
    burst(3'h7, 14'h3FF8, 16'h0005, 16'h0004);
    mode(3'h3, 14'h0003);
    check(calib_mode, 1'b0);
    burst(3'h0, 14'h1000, 16'h0000, 16'h0000);
    mode(3'h0, 14'h0012);
    mode(3'h1, 14'h0008);
    mode(3'h3, 14'h0004);
    burst(3'h0, 14'h1000, 16'h0009, 16'h0002);
    mode(3'h3, 14'h0000);
    check(cmd_violation, 1'b0);
  endtask
  // a mode write while the enable is low must not take effect
  task automatic t_freeze();
    @(negedge mclk);
    clk_en = 1'b0;
    repeat (3) @(negedge ck);
    mode(3'h3, 14'h0004);
    check(calib_mode, 1'b0);
    @(negedge mclk);
    clk_en = 1'b1;
    repeat (3) @(negedge ck);
    check(calib_mode, 1'b0);
  endtask
  // a write in calibration mode, a reset in the middle of the mode, then
  // calibration entry with a row open and a leveling exit with odt high
  task automatic t_violation();
    mode(3'h3, 14'h0004);
    i_dtmr_ctrl_model.send(4'h4, 3'h0, 14'h0000);
    repeat (5) @(negedge mclk);
    check({calib_mode, cmd_violation}, 2'h3);
    do_reset();
    check({calib_mode, cmd_violation}, 2'h0);
    i_dtmr_ctrl_model.send(4'h3, 3'h2, 14'h0000);
    mode(3'h3, 14'h0004);
    check(cmd_violation, 1'b1);
    do_reset();
    mode(3'h1, 14'h0080);
    i_dtmr_ctrl_model.drive_odt(1'b1);
    i_dtmr_ctrl_model.send(4'h0, 3'h1, 14'h0000);
    i_dtmr_ctrl_model.drive_odt(1'b0);
    repeat (5) @(negedge mclk);
    check({wl_mode, cmd_violation}, 2'h1);
  endtask

  initial begin
    do_reset();
    check({mrs_ready, cmd_ready, cmd_violation}, 3'h6);
    t_leveling();
    t_calib();
    t_freeze();
    t_violation();
    finish_test();
  end
  // traffic takes near 66 us; six times that means a hang
  initial begin
    #400_000;
    fail_count++;
    finish_test();
  end
endmodule

`default_nettype wire
